// *** rtl/cwe_consts.vh ***
// constants for the writeback/evict control block
`ifndef CWE_CONSTS_VH
`define CWE_CONSTS_VH
// line states
`define CWE_ST_W        3
`define CWE_ST_I        3'h0
`define CWE_ST_UC       3'h1
`define CWE_ST_SC       3'h2
`define CWE_ST_UD       3'h3
`define CWE_ST_SD       3'h4
// write address channel commands
`define CWE_OP_W        3
`define CWE_OP_WBACK    3'h0
`define CWE_OP_WCLEAN   3'h1
`define CWE_OP_EVICT    3'h2
`define CWE_OP_WUNQ     3'h3
`define CWE_OP_WLUNQ    3'h4
// request error codes
`define CWE_ERR_W       3
`define CWE_ERR_NONE    3'h0
`define CWE_ERR_STATE   3'h1
`define CWE_ERR_REGION  3'h2
`define CWE_ERR_NOFILT  3'h3
`define CWE_ERR_SNPDATA 3'h4
`define CWE_ERR_OPCODE  3'h5
`endif

// *** rtl/cwe_end_state.v ***
// legal and expected end state of a line after a write-group transaction
`timescale 1ns/1ps
`include "cwe_consts.vh"
module cwe_end_state (
    input  wire [`CWE_OP_W-1:0] op,
    input  wire [`CWE_ST_W-1:0] start_st,
    input  wire                 shareable,
    input  wire                 snoop_filter,
    input  wire [`CWE_ST_W-1:0] want_st,
    output reg                  start_ok,
    output reg  [`CWE_ST_W-1:0] expect_st,
    output reg                  end_ok
);
    wire dirty = (start_st == `CWE_ST_UD) || (start_st == `CWE_ST_SD);
    wire clean = (start_st == `CWE_ST_UC) || (start_st == `CWE_ST_SC);
    wire is_i  = (want_st == `CWE_ST_I);
    wire is_uc = (want_st == `CWE_ST_UC);
    wire is_sc = (want_st == `CWE_ST_SC);
    wire from_ud = (start_st == `CWE_ST_UD);

    always @* begin
        start_ok  = 1'b0;
        expect_st = `CWE_ST_I;
        end_ok    = 1'b0;
        case (op)
            `CWE_OP_WBACK: begin
                start_ok = dirty; // RULE1
                expect_st = `CWE_ST_I; // RULE2
                if (!shareable)
                    end_ok = is_i || is_uc || is_sc; // RULE5
                else if (snoop_filter)
                    end_ok = is_i; // RULE4
                else
                    end_ok = is_i || is_sc || (from_ud && is_uc); // RULE4
            end
            `CWE_OP_WCLEAN: begin
                start_ok = dirty; // RULE1
                if (!shareable) begin
                    expect_st = `CWE_ST_UC; // RULE7
                    end_ok = is_i || is_uc || is_sc; // RULE7
                end else begin
                    expect_st = from_ud ? `CWE_ST_UC : `CWE_ST_SC; // RULE3 RULE6
                    if (snoop_filter)
                        end_ok = is_sc || (from_ud && is_uc); // RULE6
                    else
                        end_ok = is_i || is_sc || (from_ud && is_uc); // RULE6
                end
            end
            `CWE_OP_EVICT: begin
                start_ok = clean; // RULE17
                expect_st = `CWE_ST_I; // RULE17
                end_ok = is_i && snoop_filter; // RULE17
            end
            default: begin
                start_ok = 1'b1;
                expect_st = start_st;
                end_ok = 1'b1;
            end
        endcase
    end
endmodule // cwe_end_state

// *** rtl/cwe_ctrl.v ***
// issue ordering and line state control for writeback, writeclean and evict
// Function
// RULE1: writeback/writeclean write dirty lines, any region
// RULE2: shareable writeback ends with line deallocated
// RULE3: shareable writeclean keeps line allocated
// RULE4: shareable writeback end states by filter
// RULE5: non-shareable writeback may end I, UC, SC
// RULE6: shareable writeclean end states by filter
// RULE7: non-shareable writeclean expected UC, I/UC/SC legal
// RULE8: atomic store then write: combine both changes
// RULE9: unique writes need every snoop completable
// RULE10: unique writes wait for writebacks to drain
// RULE11: no writebacks while unique writes outstanding
// RULE12: snoops served without writebacks during unique
// RULE13: unique writes need dataless snoops or snoop data
// RULE14: restricted snoop handling only during unique writes
// RULE15: evict on write channel, no data
// RULE16: evict only shareable, only with snoop filter
// RULE17: evict from UC/SC ends invalid
// RULE18: cached unique writes only under snoop restrictions
// RULE19: write group goes on write address channel
// RULE20: invalid to valid only after full-line store
// RULE21: separate outstanding counts gate each class
`timescale 1ns/1ps
`include "cwe_consts.vh"
module cwe_ctrl #(
    parameter CNT_W = 4
) (
    input  wire                  clk,
    input  wire                  rst_n,
    // request from the cache
    input  wire                  req_valid,
    input  wire [`CWE_OP_W-1:0]  req_op,
    input  wire [31:0]           req_addr,
    input  wire [`CWE_ST_W-1:0]  req_state,
    input  wire [`CWE_ST_W-1:0]  req_end_state,
    input  wire                  req_shareable,
    input  wire                  req_store,
    input  wire                  req_full_line,
    input  wire                  snoop_filter,
    input  wire                  dataless_snoops,
    input  wire                  snoop_data_chan,
    // answer to the cache
    output reg                   req_ready,
    output reg                   req_done,
    output reg  [`CWE_ERR_W-1:0] req_err,
    output reg  [`CWE_ST_W-1:0]  expect_state,
    output reg                   end_legal,
    // write address channel
    output reg                   aw_valid,
    input  wire                  aw_ready,
    output reg  [`CWE_OP_W-1:0]  aw_op,
    output reg  [31:0]           aw_addr,
    output reg                   aw_has_data,
    // write response
    input  wire                  b_valid,
    input  wire [`CWE_OP_W-1:0]  b_op,
    // snoop handling mode
    output reg                   snoop_restrict,
    output reg                   snoop_no_wb
);
    localparam S_IDLE = 3'b001;
    localparam S_AW   = 3'b010;
    localparam S_DONE = 3'b100;

    reg [2:0]       state_r;
    reg [CNT_W-1:0] wb_cnt_r;
    reg [CNT_W-1:0] wu_cnt_r;

    wire            start_ok;
    wire [`CWE_ST_W-1:0] expect_w;
    wire            end_ok;
    // store of an atomic pair makes the line dirty before the write
    reg  [`CWE_ST_W-1:0] eff_state;
    reg  [`CWE_ERR_W-1:0] chk_err;
    reg             is_wb;
    reg             is_wu;

    function is_wb_class;
        input [`CWE_OP_W-1:0] op;
        is_wb_class = (op == `CWE_OP_WBACK) || (op == `CWE_OP_WCLEAN);
    endfunction

    function is_wu_class;
        input [`CWE_OP_W-1:0] op;
        is_wu_class = (op == `CWE_OP_WUNQ) || (op == `CWE_OP_WLUNQ);
    endfunction

    always @* begin
        eff_state = req_state;
        if (req_store) begin
            // RULE8: a store leaves UC/UD dirty unique, shared ones shared dirty
            if (req_state == `CWE_ST_UC || req_state == `CWE_ST_UD)
                eff_state = `CWE_ST_UD; // RULE8
            else if (req_state == `CWE_ST_SC || req_state == `CWE_ST_SD)
                eff_state = `CWE_ST_SD; // RULE8
            else if (req_full_line)
                eff_state = `CWE_ST_UD; // RULE20
        end
    end

    cwe_end_state u_end (
        .op           (req_op),
        .start_st     (eff_state),
        .shareable    (req_shareable),
        .snoop_filter (snoop_filter),
        .want_st      (req_end_state),
        .start_ok     (start_ok),
        .expect_st    (expect_w),
        .end_ok       (end_ok)
    );

    always @* begin
        is_wb = is_wb_class(req_op);
        is_wu = is_wu_class(req_op);
        chk_err = `CWE_ERR_NONE;
        if (!(is_wb || is_wu || req_op == `CWE_OP_EVICT))
            chk_err = `CWE_ERR_OPCODE;
        else if (req_op == `CWE_OP_EVICT && !req_shareable)
            chk_err = `CWE_ERR_REGION; // RULE16
        else if (req_op == `CWE_OP_EVICT && !snoop_filter)
            chk_err = `CWE_ERR_NOFILT; // RULE16
        else if (is_wu && !(dataless_snoops || snoop_data_chan))
            chk_err = `CWE_ERR_SNPDATA; // RULE13 RULE18
        else if (is_wu && !req_shareable)
            chk_err = `CWE_ERR_REGION;
        else if (req_store && req_state == `CWE_ST_I && !req_full_line)
            chk_err = `CWE_ERR_STATE; // RULE20
        else if (!start_ok)
            chk_err = `CWE_ERR_STATE; // RULE1
    end

    // ordering gate: each class waits for the other to drain
    wire gate_ok = is_wb ? (wu_cnt_r == {CNT_W{1'b0}}) :  // RULE11 RULE21
                   is_wu ? (wb_cnt_r == {CNT_W{1'b0}}) :  // RULE10 RULE21
                   1'b1;
    wire wb_full = &wb_cnt_r;
    wire wu_full = &wu_cnt_r;
    wire cnt_ok  = !((is_wb && wb_full) || (is_wu && wu_full));
    wire take    = (state_r == S_IDLE) && req_valid && req_ready;
    wire aw_fire = aw_valid && aw_ready;
    wire b_wb    = b_valid && is_wb_class(b_op);
    wire b_wu    = b_valid && is_wu_class(b_op);
    wire iss_wb  = aw_fire && is_wb_class(aw_op);
    wire iss_wu  = aw_fire && is_wu_class(aw_op);

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_cnt_r <= {CNT_W{1'b0}};
            wu_cnt_r <= {CNT_W{1'b0}};
        end else begin
            if (iss_wb && !b_wb)
                wb_cnt_r <= wb_cnt_r + 1'b1; // RULE21
            else if (b_wb && !iss_wb && wb_cnt_r != {CNT_W{1'b0}})
                wb_cnt_r <= wb_cnt_r - 1'b1; // RULE21
            if (iss_wu && !b_wu)
                wu_cnt_r <= wu_cnt_r + 1'b1; // RULE21
            else if (b_wu && !iss_wu && wu_cnt_r != {CNT_W{1'b0}})
                wu_cnt_r <= wu_cnt_r - 1'b1; // RULE21
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r      <= S_IDLE;
            req_ready    <= 1'b0;
            req_done     <= 1'b0;
            req_err      <= `CWE_ERR_NONE;
            expect_state <= `CWE_ST_I;
            end_legal    <= 1'b0;
            aw_valid     <= 1'b0;
            aw_op        <= `CWE_OP_WBACK;
            aw_addr      <= 32'h00000000;
            aw_has_data  <= 1'b0;
        end else begin
            req_done <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    // ready in idle, dropped while a presented request is held back by the gate or a full count
                    req_ready <= 1'b1;
                    if (take) begin
                        req_ready    <= 1'b0;
                        req_err      <= chk_err;
                        expect_state <= expect_w; // RULE2 RULE3
                        end_legal    <= end_ok && (chk_err == `CWE_ERR_NONE);
                        if (chk_err != `CWE_ERR_NONE) begin
                            state_r <= S_DONE;
                        end else if (gate_ok && cnt_ok) begin
                            aw_valid    <= 1'b1; // RULE19
                            aw_op       <= req_op;
                            aw_addr     <= req_addr;
                            aw_has_data <= (req_op != `CWE_OP_EVICT); // RULE15
                            state_r     <= S_AW;
                        end else begin
                            // held back: retry by re-presenting later
                            req_ready <= 1'b0;
                            state_r   <= S_IDLE;
                        end
                    end
                end
                S_AW: begin
                    if (aw_ready) begin
                        aw_valid <= 1'b0;
                        state_r  <= S_DONE;
                    end
                end
                S_DONE: begin
                    req_done <= 1'b1;
                    state_r  <= S_IDLE;
                end
                default: begin
                    state_r  <= S_IDLE;
                    aw_valid <= 1'b0;
                end
            endcase
            // stall acceptance while the ordering gate would refuse it
            if (state_r == S_IDLE && req_valid && !take && (!gate_ok || !cnt_ok))
                req_ready <= 1'b0; // RULE10 RULE11
            else if (state_r == S_IDLE && !take)
                req_ready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // restricted snoop mode only while a unique write is outstanding
    wire wu_live = (wu_cnt_r != {CNT_W{1'b0}}) || iss_wu;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            snoop_restrict <= 1'b0;
            snoop_no_wb    <= 1'b0;
        end else begin
            snoop_restrict <= wu_live; // RULE9 RULE14
            snoop_no_wb    <= wu_live; // RULE12
        end
    end
endmodule // cwe_ctrl

// *** dv/cwe_ctrl_sva.sv ***
// assertions on the write-group issue controller ports
`timescale 1ns/1ps
`include "cwe_consts.vh"
module cwe_ctrl_sva (
    input wire       clk,
    input wire       rst_n,
    input wire       req_valid,
    input wire       req_ready,
    input wire       req_done,
    input wire       aw_valid,
    input wire       aw_ready,
    input wire [2:0] aw_op,
    input wire       aw_has_data,
    input wire       b_valid,
    input wire [2:0] b_op,
    input wire       snoop_filter,
    input wire       snoop_restrict,
    input wire       snoop_no_wb
);
    reg  [4:0] wb_r;
    reg  [4:0] un_r;
    wire       aw_wb = aw_op == `CWE_OP_WBACK || aw_op == `CWE_OP_WCLEAN;
    wire       aw_un = aw_op == `CWE_OP_WUNQ || aw_op == `CWE_OP_WLUNQ;
    wire       b_wb  = b_valid && (b_op == `CWE_OP_WBACK || b_op == `CWE_OP_WCLEAN);
    wire       b_un  = b_valid && (b_op == `CWE_OP_WUNQ || b_op == `CWE_OP_WLUNQ);
    wire       go    = aw_valid && aw_ready;
    // own count of handshakes minus responses, per class
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_r <= 5'h00;
            un_r <= 5'h00;
        end else begin
            wb_r <= wb_r + {4'h0, go && aw_wb} - {4'h0, b_wb};
            un_r <= un_r + {4'h0, go && aw_un} - {4'h0, b_un};
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_evict_no_data: assert property (aw_valid && aw_op == `CWE_OP_EVICT |-> !aw_has_data)
        else $error("evict with data");
    chk_write_has_data: assert property (aw_valid && aw_wb |-> aw_has_data)
        else $error("writeback without data");
    chk_aw_held: assert property (aw_valid && !aw_ready |=> aw_valid && $stable(aw_op))
        else $error("write request dropped early");
    chk_evict_filter: assert property (aw_valid && aw_op == `CWE_OP_EVICT |-> snoop_filter)
        else $error("evict without filter");
    chk_unique_wait: assert property ($rose(aw_valid) && aw_un |-> wb_r == 5'h00)
        else $error("unique write over writeback");
    chk_wb_blocked: assert property ($rose(aw_valid) && aw_wb |-> un_r == 5'h00)
        else $error("writeback over unique write");
    chk_restrict_on: assert property (un_r != 5'h00 |-> snoop_restrict && snoop_no_wb)
        else $error("snoop restriction missing");
    chk_ready_back: assert property (req_done && !req_valid |=> req_ready && !req_done)
        else $error("ready not back after done");
endmodule // cwe_ctrl_sva
bind cwe_ctrl cwe_ctrl_sva u_sva (.*);

// *** dv/cwe_ic_model.sv ***
// interconnect model: accepts write requests, answers with responses
`timescale 1ns/1ps
module cwe_ic_model (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       aw_valid,
    input  wire [2:0] aw_op,
    input  wire       hold,
    output reg        aw_ready,
    output reg        b_valid,
    output reg  [2:0] b_op
);
    reg [2:0] q_r [0:15];
    reg [3:0] wp_r;
    reg [3:0] rp_r;
    reg [1:0] dly_r;
    reg       slow_r;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {aw_ready, b_valid, b_op, wp_r, rp_r, dly_r, slow_r} <= 16'h0000;
        end else begin
            b_valid <= 1'b0;
            b_op <= ~b_op;
            if (aw_valid && aw_ready) begin
                aw_ready <= 1'b0;
                q_r[wp_r] <= aw_op;
                wp_r <= wp_r + 4'h1;
                slow_r <= ~slow_r;
                dly_r <= 2'h0;
            end else if (aw_valid) begin
                // alternate one-cycle and three-cycle acceptance
                dly_r <= dly_r + 2'h1;
                aw_ready <= dly_r >= {slow_r, 1'b0};
            end
            if (!hold && wp_r != rp_r) begin
                b_valid <= 1'b1;
                b_op <= q_r[rp_r];
                rp_r <= rp_r + 4'h1;
            end
        end
    end
endmodule // cwe_ic_model

// *** dv/cwe_ctrl_tb_top.sv ***
// self-checking bench for the write-group issue controller
`timescale 1ns/1ps
`include "cwe_consts.vh"
module cwe_ctrl_tb_top;
    localparam [2:0] WB = `CWE_OP_WBACK, WC = `CWE_OP_WCLEAN, EV = `CWE_OP_EVICT;
    localparam [2:0] WU = `CWE_OP_WUNQ, WL = `CWE_OP_WLUNQ, I = `CWE_ST_I, UC = `CWE_ST_UC;
    localparam [2:0] SC = `CWE_ST_SC, UD = `CWE_ST_UD, SD = `CWE_ST_SD, OK = `CWE_ERR_NONE;
    reg         clk = 0, rst_n = 0, req_valid = 0, req_shareable = 0, req_store = 0;
    reg         req_full_line = 0, snoop_filter = 0, dataless_snoops = 1;
    reg         snoop_data_chan = 0, hold = 0, taken = 0, seen_data = 0;
    reg  [2:0]  req_op = 0, req_state = 0, req_end_state = 0, seen_op = 0;
    reg  [31:0] req_addr = 32'h0;
    reg  [31:0] seen_addr = 32'h0;
    wire        req_ready, req_done, end_legal, aw_valid, aw_ready, aw_has_data;
    wire        b_valid, snoop_restrict, snoop_no_wb;
    wire [2:0]  req_err, expect_state, aw_op, b_op;
    wire [31:0] aw_addr;
    integer     error_cnt = 0, comparisons = 0, n = 0;
    always #4 clk = ~clk;
    cwe_ctrl DUT (.*);
    cwe_ic_model u_ic (.*);
    always @(posedge clk) begin
        if (aw_valid && aw_ready)
            {seen_op, seen_data, seen_addr} <= {aw_op, aw_has_data, aw_addr};
    end
    task report_and_stop;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
            if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask
    task chk(input [31:0] exp, input [31:0] got, input [8*16-1:0] what);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("BAD %0s expected %0h seen %0h", what, exp, got);
            end
        end
    endtask
    // request held until the design shows it was taken: a gated take raises neither aw_valid nor req_done
    task go(input integer lim);
        begin
            req_addr = req_addr + 32'h40;
            req_valid = 1'b1;
            n = 0;
            while (aw_valid !== 1'b1 && req_done !== 1'b1 && n < lim) begin
                @(negedge clk);
                n = n + 1;
            end
            taken = n < lim;
            req_valid = 1'b0;
            // short limits are refusal windows; a long one running out is a hang
            if (!taken && lim >= 50) error_cnt = error_cnt + 1;
            if (!taken && lim >= 50) report_and_stop;
            while (taken && req_done !== 1'b1 && n < 100) begin
                @(negedge clk);
                n = n + 1;
            end
            if (n >= 100) error_cnt = error_cnt + 1;
            if (n >= 100) report_and_stop;
            @(negedge clk);
        end
    endtask
    task one(input [2:0] op, st, en, input sh, sf, input [1:0] so, input [2:0] ee, ex, input el);
        begin
            snoop_filter = sf;
            {req_op, req_state, req_end_state, req_shareable, req_store, req_full_line} =
                {op, st, en, sh, so};
            go(50);
            chk(1, taken, "taken");
            chk(ee, req_err, "err");
            chk(el, end_legal, "legal");
            if (ee == OK) chk(ex, expect_state, "expect");
            if (ee == OK) chk({op, op != EV}, {seen_op, seen_data}, "aw");
            if (ee == OK) chk(req_addr, seen_addr, "addr");
        end
    endtask
    task t_wb;
        begin
            one(WB, UD, I, 1, 1, 0, OK, I, 1);
            one(WB, UD, UC, 1, 1, 0, OK, I, 0);
            one(WB, UD, UC, 1, 0, 0, OK, I, 1);
            one(WB, SD, UC, 1, 0, 0, OK, I, 0);
            one(WB, SD, UC, 0, 1, 0, OK, I, 1);
            one(WB, UC, I, 1, 1, 0, `CWE_ERR_STATE, I, 0);
            one(3'h7, UD, I, 1, 1, 0, `CWE_ERR_OPCODE, I, 0);
            $display("writeback states done");
        end
    endtask
    task t_wc;
        begin
            one(WC, UD, SC, 1, 1, 0, OK, UC, 1);
            one(WC, UD, I, 1, 1, 0, OK, UC, 0);
            one(WC, SD, I, 1, 0, 0, OK, SC, 1);
            one(WC, SD, I, 0, 1, 0, OK, UC, 1);
            $display("writeclean states done");
        end
    endtask
    task t_ev;
        begin
            one(EV, UC, I, 1, 1, 0, OK, I, 1);
            one(EV, SC, UC, 1, 1, 0, OK, I, 0);
            one(EV, SC, I, 0, 1, 0, `CWE_ERR_REGION, I, 0);
            one(EV, UC, I, 1, 0, 0, `CWE_ERR_NOFILT, I, 0);
            one(EV, UD, I, 1, 1, 0, `CWE_ERR_STATE, I, 0);
            $display("evict done");
        end
    endtask
    task t_st;
        begin
            one(WB, I, I, 1, 1, 3, OK, I, 1);
            one(WC, SC, SC, 1, 1, 2, OK, SC, 1);
            one(WB, I, I, 1, 1, 2, `CWE_ERR_STATE, I, 0);
            $display("atomic store done");
        end
    endtask
    task t_ord;
        begin
            hold = 1'b1;
            one(WB, UD, I, 1, 1, 0, OK, I, 1);
            req_op = WU;
            go(12);
            chk(0, taken, "unique early");
            hold = 1'b0;
            for (n = 0; n < 20 && b_valid !== 1'b1; n = n + 1) @(negedge clk);
            if (b_valid !== 1'b1) error_cnt = error_cnt + 1;
            if (b_valid !== 1'b1) report_and_stop;
            hold = 1'b1;
            {req_op, req_state, req_end_state} = {WU, I, I};
            go(50);
            chk({1'b1, WU}, {taken, seen_op}, "unique");
            chk(2'b11, {snoop_restrict, snoop_no_wb}, "restrict");
            {req_op, req_state} = {WB, UD};
            go(12);
            chk(0, taken, "wb early");
            hold = 1'b0;
            for (n = 0; n < 20 && snoop_restrict !== 1'b0; n = n + 1) @(negedge clk);
            chk(0, snoop_restrict, "restrict off");
            if (snoop_restrict !== 1'b0) report_and_stop;
            $display("ordering done");
        end
    endtask
    task t_snp;
        begin
            {dataless_snoops, req_op, req_state, req_end_state} = {1'b0, WL, I, I};
            go(50);
            chk(`CWE_ERR_SNPDATA, req_err, "no snoop path");
            snoop_data_chan = 1'b1;
            go(50);
            chk({OK, WL}, {req_err, seen_op}, "snoop data");
            $display("unique snoop path done");
        end
    endtask
    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_wb;
        t_wc;
        t_ev;
        t_st;
        t_ord;
        t_snp;
        report_and_stop;
    end
endmodule // cwe_ctrl_tb_top
